// [core/plk_link.sv]
// Link-clock side of the overdrive link: command shifter and read-data driver
`timescale 1ns/10ps
`include "plk_map.svh"
module plk_link (
	// Link clock and reset
	input wire logic link_clk_i,
	input wire logic rst_n_i,
	// Link enable level from the system domain
	input wire logic link_en_i,
	// Serial data from the negative pin
	input wire logic sdi_i,
	// Write toward the system domain
	output plk_pkg::plk_reg_wr_t wr_o,
	output logic wr_tgl_o,
	// Read handshake with the system domain
	output logic [15:0] rd_addr_o,
	output logic rd_req_o,
	input wire logic rd_ack_i,
	input wire logic [7:0] rd_data_i,
	// Serial data toward the negative pin
	output logic sdo_o,
	output logic sdo_oe_o
);
	logic [1:0] en_s;
	logic [1:0] ack_s;
	logic [5:0] cnt;
	logic wr_flag;
	logic [30:0] sh;
	logic [31:0] word;

	assign word = {sh, sdi_i};

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_s <= 2'h0;
			ack_s <= 2'h0;
		end else begin
			en_s <= {en_s[0], link_en_i};
			ack_s <= {ack_s[0], rd_ack_i};
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 6'h00;
			wr_flag <= 1'b0;
			sh <= 31'h0;
			wr_o <= '0;
			wr_tgl_o <= 1'b0;
			rd_addr_o <= 16'h0000;
			rd_req_o <= 1'b0;
		end else if (!en_s[1]) begin
			cnt <= 6'h00;
			rd_req_o <= 1'b0;
		end else begin
			sh <= word[30:0];
			if (cnt == 6'h00) begin
				// Idle low line is skipped until a start bit
				if (sdi_i) begin
					cnt <= 6'h01;
				end
			end else if (wr_flag && cnt == `PLK_FRAME_WRITE - 6'h01) begin
				cnt <= 6'h00;
				wr_o <= {word[23:8], word[7:0]};
				wr_tgl_o <= ~wr_tgl_o;
			end else if (!wr_flag && cnt == `PLK_FRAME_READ - 6'h01) begin
				cnt <= 6'h00;
				rd_req_o <= 1'b0;
			end else begin
				cnt <= cnt + 6'h01;
			end
			if (cnt == 6'h01) begin
				wr_flag <= sdi_i;
			end
			if (!wr_flag && cnt == `PLK_FRAME_ADDR_DONE - 6'h01) begin
				rd_addr_o <= word[15:0];
				rd_req_o <= 1'b1;
			end
		end
	end

	// Falling edge drive gives the host a full half period of setup
	always_ff @(negedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sdo_o <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			sdo_oe_o <= en_s[1] && !wr_flag && cnt >= `PLK_FRAME_WRITE;
			sdo_o <= ack_s[1] & rd_data_i[3'(6'h27 - cnt)];
		end
	end
endmodule

// [core/plk_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PLK_MAP_SVH
`define PLK_MAP_SVH
`define PLK_MAIN_CONFIGURATION 16'h0000
`define PLK_LAMP_DRIVE_CONFIGURATION 16'h0001
`define PLK_LAMP_INITIAL_DUTY 16'h0002
`define PLK_NVM_UNLOCK_AND_INDEX_CHECK 16'h000b
`define PLK_LAMP_ACTUAL_DUTY 16'h0010
`define PLK_COMMUTATION_SETUP 16'h0100
`define PLK_INTERPOLATION_LOW_BYTE 16'h0101
`define PLK_INTERPOLATION_HIGH_AND_DIVIDER 16'h0102
`define PLK_QUADRATURE_HYSTERESIS 16'h0103
`define PLK_COMMUTATION_HYSTERESIS 16'h0104
`define PLK_INPUT_FREQUENCY_ALARM_LEVEL 16'h0105
`define PLK_QUADRATURE_FREQUENCY_LIMIT 16'h0106
`define PLK_INDEX_CONFIG_A 16'h0107
`define PLK_INDEX_PULSE_WIDTH 16'h0108
`define PLK_OUTPUT_ENABLES_POLARITIES 16'h0109
`define PLK_INDEX_PHASE_HIGH 16'h010a
`define PLK_COMMUTATION_PHASE_HIGH 16'h010b
`define PLK_PHASE_LOW_BITS 16'h010c
`define PLK_SINE_SAMPLE_HIGH 16'h021a
`define PLK_COSINE_SAMPLE_HIGH 16'h021c
`define PLK_TRACKING_FILTER_SETUP 16'h0300
`define PLK_TRACKING_LAG_THRESHOLD 16'h0301
`define PLK_TRACKING_LOOP_GAINS 16'h0302
`define PLK_ALARM_BEHAVIOUR_SETUP 16'h0400
`define PLK_ALARM_SELECT 16'h0401
`define PLK_ALARM_IRQ_ENABLE 16'h0402
`define PLK_ALARM_TRISTATE_ENABLE 16'h0403
`define PLK_ALARM_LIVE_STATE 16'h0404
`define PLK_ALARM_LATCHED_STATE 16'h0405
`define PLK_FATAL_FAULT_FLAGS 16'h0406
`define PLK_NVM_ADDRESS 16'h0601
`define PLK_NVM_DATA 16'h0602
`define PLK_NVM_READ_VALIDITY 16'h0603
`define PLK_OPERATION_COMMAND 16'h4000
`define PLK_STARTUP_BEHAVIOUR 16'h4001
`define PLK_ADAPTATION_ENABLES 16'h4002
`define PLK_ADAPTATION_OPTIONS 16'h4003
`define PLK_AMPLITUDE_TARGET 16'h4004
`define PLK_AMPLITUDE_LOWER_LIMIT 16'h4005
`define PLK_AMPLITUDE_UPPER_LIMIT 16'h4006
`define PLK_SINE_OFFSET_BASELINE 16'h4007
`define PLK_COSINE_OFFSET_BASELINE 16'h4008
`define PLK_OFFSET_CORRECTION_LIMIT 16'h4009
`define PLK_OFFSET_RESIDUE_THRESHOLD 16'h400a
`define PLK_BALANCE_BASELINE 16'h400b
`define PLK_BALANCE_CORRECTION_LIMIT 16'h400c
`define PLK_BALANCE_RESIDUE_THRESHOLD 16'h400d
`define PLK_QUADRATURE_PHASE_BASELINE 16'h400e
`define PLK_LINK_OFF_BIT 5
`define PLK_ABZ_ENABLE_BIT 6
`define PLK_REG_RESET 8'h00
`define PLK_FRAME_WRITE 6'h20
`define PLK_FRAME_READ 6'h28
`define PLK_FRAME_ADDR_DONE 6'h18
`define PLK_CLK_NS 40
`define PLK_REFRESH_NS 320
`define PLK_FAST_REFRESH_NS 20
`define PLK_ACT_MIN_MS 1
`define PLK_ACT_MAX_MS 8
`endif

// [core/plk_pkg.sv]
// Types shared by the overdrive link and register logic
package plk_pkg;
	typedef enum logic [1:0] {
		PLK_ACT_IDLE = 2'b00,
		PLK_ACT_HIGH = 2'b01,
		PLK_ACT_ABORT = 2'b10,
		PLK_ACT_ON = 2'b11
	} plk_act_state_t;
	typedef enum logic [1:0] {
		PLK_RESP_POS = 2'b00,
		PLK_RESP_CAPT = 2'b01,
		PLK_RESP_ADC = 2'b10,
		PLK_RESP_REGPOS = 2'b11
	} plk_resp_sel_t;
	typedef struct packed {
		plk_resp_sel_t response_select;
		logic write_reg;
		logic [15:0] addr;
		logic [7:0] data;
	} plk_spi_cmd_t;
	typedef struct packed {
		logic signed [9:0] sine;
		logic signed [9:0] cosine;
		logic signed [7:0] index;
	} plk_adc_t;
	typedef struct packed {
		logic [13:0] cycles;
		logic [9:0] angle;
	} plk_pos_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
	} plk_reg_wr_t;
	typedef logic [8:0][7:0] plk_dyn_t;
endpackage

// [core/plk_top.sv]
// Register access: serial response formats, overdrive link and register map
// How it works
// - Signed corrected samples, refreshed every 320 ns
// - Mode 3 word: byte, count, angle
// - Mode 3 byte from previous command address
// - Fourteen-bit count, refresh rate follows output enable
// - Angle always full ten-bit resolution
// - Link reaches registers only, not position
// - Overdrive sequence of 1-8 ms activates link
// - Link stays until reset input or power
// - Command bits captured on link rising edge
// - Write flag zero means 40-bit read
// - Host releases line; device drives data byte
// - Read address taken from bits 31:16
// - Line returns to input after read
// - Write stores bits 7:0 at bits 23:8
// - Static registers change only by writes, restore
// - Dynamic registers read-only except correction values
// - Reserved and unlisted addresses stay untouched
// - Static register writes act at once
// - Mode 2 word: zeros, sine, cosine, index
// - Main configuration bit 5 blocks activation
`timescale 1ns/10ps
`include "plk_map.svh"
module plk_top #(
	parameter int ACT_MIN_CYC = (`PLK_ACT_MIN_MS * 1000000 + `PLK_CLK_NS - 1) / `PLK_CLK_NS,
	parameter int ACT_MAX_CYC = (`PLK_ACT_MAX_MS * 1000000) / `PLK_CLK_NS
) (
	// System clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Link clock, taken from the positive pin
	input wire logic link_clk_i,
	// Pins
	input wire logic external_reset_n_i,
	input wire logic qa_pos_i,
	output logic qa_pos_o,
	output logic qa_pos_oe_o,
	input wire logic qa_neg_i,
	output logic qa_neg_o,
	output logic qa_neg_oe_o,
	output logic link_sdo_o,
	output logic link_sdo_oe_o,
	// Normal quadrature source
	input wire logic quad_a_i,
	// Host serial port command and response
	input wire logic spi_cmd_valid_i,
	input wire plk_pkg::plk_spi_cmd_t spi_cmd_i,
	output logic [31:0] spi_resp_o,
	// Signal path values
	input wire plk_pkg::plk_adc_t adc_i,
	input wire plk_pkg::plk_pos_t pos_i,
	input wire plk_pkg::plk_dyn_t dyn_i,
	// Startup restore from nonvolatile memory
	input wire logic restore_valid_i,
	input wire plk_pkg::plk_reg_wr_t restore_i,
	// Configuration and status
	output logic [7:0] cfg_main_o,
	output logic [7:0] cfg_output_o,
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic count_valid_o,
	output logic link_active_o
);
	localparam int NRW = 39;
	localparam int NRO = 9;
	localparam int ACT_W = 18;
	localparam int REF_CYC = `PLK_REFRESH_NS / `PLK_CLK_NS;
	localparam int FAST_CYC = (`PLK_FAST_REFRESH_NS < `PLK_CLK_NS) ? 1 :
		`PLK_FAST_REFRESH_NS / `PLK_CLK_NS;
	// Table positions of registers the block itself uses
	localparam int I_MAIN = 0;
	localparam int I_UNLOCK = 3;
	localparam int I_INTER_LO = 5;
	localparam int I_INTER_HI = 6;
	localparam int I_OUTPUT = 13;
	localparam int I_CMD = 25;
	localparam logic [15:0] RW_ADDR [NRW] = '{
		`PLK_MAIN_CONFIGURATION,
		`PLK_LAMP_DRIVE_CONFIGURATION,
		`PLK_LAMP_INITIAL_DUTY,
		`PLK_NVM_UNLOCK_AND_INDEX_CHECK,
		`PLK_COMMUTATION_SETUP,
		`PLK_INTERPOLATION_LOW_BYTE,
		`PLK_INTERPOLATION_HIGH_AND_DIVIDER,
		`PLK_QUADRATURE_HYSTERESIS,
		`PLK_COMMUTATION_HYSTERESIS,
		`PLK_INPUT_FREQUENCY_ALARM_LEVEL,
		`PLK_QUADRATURE_FREQUENCY_LIMIT,
		`PLK_INDEX_CONFIG_A,
		`PLK_INDEX_PULSE_WIDTH,
		`PLK_OUTPUT_ENABLES_POLARITIES,
		`PLK_COMMUTATION_PHASE_HIGH,
		`PLK_PHASE_LOW_BITS,
		`PLK_TRACKING_FILTER_SETUP,
		`PLK_TRACKING_LAG_THRESHOLD,
		`PLK_TRACKING_LOOP_GAINS,
		`PLK_ALARM_BEHAVIOUR_SETUP,
		`PLK_ALARM_SELECT,
		`PLK_ALARM_IRQ_ENABLE,
		`PLK_ALARM_TRISTATE_ENABLE,
		`PLK_NVM_ADDRESS,
		`PLK_STARTUP_BEHAVIOUR,
		`PLK_OPERATION_COMMAND,
		`PLK_ADAPTATION_ENABLES,
		`PLK_ADAPTATION_OPTIONS,
		`PLK_AMPLITUDE_TARGET,
		`PLK_AMPLITUDE_LOWER_LIMIT,
		`PLK_AMPLITUDE_UPPER_LIMIT,
		`PLK_SINE_OFFSET_BASELINE,
		`PLK_COSINE_OFFSET_BASELINE,
		`PLK_OFFSET_CORRECTION_LIMIT,
		`PLK_OFFSET_RESIDUE_THRESHOLD,
		`PLK_BALANCE_BASELINE,
		`PLK_BALANCE_CORRECTION_LIMIT,
		`PLK_BALANCE_RESIDUE_THRESHOLD,
		`PLK_QUADRATURE_PHASE_BASELINE
	};
	// Order matches the lanes of dyn_i
	localparam logic [15:0] RO_ADDR [NRO] = '{
		`PLK_LAMP_ACTUAL_DUTY,
		`PLK_INDEX_PHASE_HIGH,
		`PLK_SINE_SAMPLE_HIGH,
		`PLK_COSINE_SAMPLE_HIGH,
		`PLK_ALARM_LIVE_STATE,
		`PLK_ALARM_LATCHED_STATE,
		`PLK_FATAL_FAULT_FLAGS,
		`PLK_NVM_DATA,
		`PLK_NVM_READ_VALIDITY
	};

	plk_pkg::plk_act_state_t act_state;
	logic [ACT_W-1:0] act_cnt;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic both_hi;
	logic both_lo;
	logic [7:0] rw_q [NRW];
	plk_pkg::plk_reg_wr_t lk_wr;
	logic lk_tgl;
	logic [2:0] wtgl_s;
	logic lk_we;
	logic [15:0] lk_rd_addr;
	logic lk_rd_req;
	logic [1:0] rreq_s;
	logic rd_ack;
	logic [7:0] rd_data;
	logic spi_we;
	plk_pkg::plk_resp_sel_t resp_sel;
	logic [15:0] resp_addr;
	logic [3:0] ref_cnt;
	logic ref_tick;
	logic [3:0] fast_cnt;
	logic fast_tick;
	plk_pkg::plk_adc_t adc_q;
	plk_pkg::plk_pos_t pos_q;

	function automatic logic [7:0] rd_reg(input logic [15:0] a);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < NRW; i++) begin
			if (RW_ADDR[i] == a) begin
				v = rw_q[i];
			end
		end
		for (int i = 0; i < NRO; i++) begin
			if (RO_ADDR[i] == a) begin
				v = dyn_i[i];
			end
		end
		return v;
	endfunction

	// Pin synchronisers reset to idle levels, so no false start follows
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1 <= 3'h4;
			pin_s2 <= 3'h4;
		end else begin
			pin_s1 <= {external_reset_n_i, qa_pos_i, qa_neg_i};
			pin_s2 <= pin_s1;
		end
	end

	// Normal drive is differential, so both pins equal means overdrive
	assign both_hi = pin_s2[1] & pin_s2[0];
	assign both_lo = ~pin_s2[1] & ~pin_s2[0];

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_state <= plk_pkg::PLK_ACT_IDLE;
			act_cnt <= '0;
			link_active_o <= 1'b0;
		end else if (!pin_s2[2]) begin
			act_state <= plk_pkg::PLK_ACT_IDLE;
			act_cnt <= '0;
			link_active_o <= 1'b0;
		end else begin
			unique case (act_state)
				plk_pkg::PLK_ACT_IDLE: begin
					act_cnt <= '0;
					if (both_hi && !rw_q[I_MAIN][`PLK_LINK_OFF_BIT]) begin
						act_state <= plk_pkg::PLK_ACT_HIGH;
					end
				end
				plk_pkg::PLK_ACT_HIGH: begin
					act_cnt <= act_cnt + ACT_W'(1);
					if (both_lo) begin
						if (act_cnt >= ACT_W'(ACT_MIN_CYC) && act_cnt <= ACT_W'(ACT_MAX_CYC)) begin
							act_state <= plk_pkg::PLK_ACT_ON;
							link_active_o <= 1'b1;
						end else begin
							act_state <= plk_pkg::PLK_ACT_IDLE;
						end
					end else if (act_cnt > ACT_W'(ACT_MAX_CYC)) begin
						act_state <= plk_pkg::PLK_ACT_ABORT;
					end
				end
				plk_pkg::PLK_ACT_ABORT: begin
					// Too long a sequence must be released before retrying
					if (!both_hi) begin
						act_state <= plk_pkg::PLK_ACT_IDLE;
					end
				end
				plk_pkg::PLK_ACT_ON: begin
					link_active_o <= 1'b1;
				end
			endcase
		end
	end

	// Normal output drive; both pins released while the link is active
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			qa_pos_o <= 1'b0;
			qa_neg_o <= 1'b0;
			qa_pos_oe_o <= 1'b0;
			qa_neg_oe_o <= 1'b0;
		end else begin
			qa_pos_o <= quad_a_i;
			qa_neg_o <= ~quad_a_i;
			qa_pos_oe_o <= act_state != plk_pkg::PLK_ACT_ON;
			qa_neg_oe_o <= act_state != plk_pkg::PLK_ACT_ON;
		end
	end

	plk_link i_plk_link (
		.link_clk_i(link_clk_i),
		.rst_n_i(rst_n_i),
		.link_en_i(link_active_o),
		.sdi_i(qa_neg_i),
		.wr_o(lk_wr),
		.wr_tgl_o(lk_tgl),
		.rd_addr_o(lk_rd_addr),
		.rd_req_o(lk_rd_req),
		.rd_ack_i(rd_ack),
		.rd_data_i(rd_data),
		.sdo_o(link_sdo_o),
		.sdo_oe_o(link_sdo_oe_o)
	);

	// Link crossings: write toggle and read request level
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wtgl_s <= 3'h0;
			rreq_s <= 2'h0;
		end else begin
			wtgl_s <= {wtgl_s[1:0], lk_tgl};
			rreq_s <= {rreq_s[0], lk_rd_req};
		end
	end

	assign lk_we = wtgl_s[2] ^ wtgl_s[1];
	assign spi_we = spi_cmd_valid_i & spi_cmd_i.write_reg;

	// Wait byte hides this round trip from the host
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_ack <= 1'b0;
			rd_data <= 8'h00;
		end else if (rreq_s[1] && !rd_ack) begin
			rd_data <= rd_reg(lk_rd_addr);
			rd_ack <= 1'b1;
		end else if (!rreq_s[1]) begin
			rd_ack <= 1'b0;
		end
	end

	// Storage: link beats the serial port, which beats restore
	for (genvar g = 0; g < NRW; g++) begin : g_reg
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				rw_q[g] <= `PLK_REG_RESET;
			end else if (lk_we && lk_wr.addr == RW_ADDR[g]) begin
				rw_q[g] <= lk_wr.data;
			end else if (spi_we && spi_cmd_i.addr == RW_ADDR[g]) begin
				rw_q[g] <= spi_cmd_i.data;
			end else if (restore_valid_i && restore_i.addr == RW_ADDR[g] &&
				g != I_UNLOCK && g != I_CMD) begin
				rw_q[g] <= restore_i.data;
			end
		end
	end

	// A command write also fires a one-cycle strobe
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_valid_o <= 1'b0;
			cmd_code_o <= 8'h00;
		end else if (lk_we && lk_wr.addr == RW_ADDR[I_CMD]) begin
			cmd_valid_o <= 1'b1;
			cmd_code_o <= lk_wr.data;
		end else if (spi_we && spi_cmd_i.addr == RW_ADDR[I_CMD]) begin
			cmd_valid_o <= 1'b1;
			cmd_code_o <= spi_cmd_i.data;
		end else begin
			cmd_valid_o <= 1'b0;
		end
	end

	assign cfg_main_o = rw_q[I_MAIN];
	assign cfg_output_o = rw_q[I_OUTPUT];

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_valid_o <= 1'b0;
		end else begin
			count_valid_o <= {rw_q[I_INTER_HI][1:0], rw_q[I_INTER_LO]} == 10'h000;
		end
	end

	// Refresh timers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_cnt <= 4'h0;
			ref_tick <= 1'b0;
		end else begin
			ref_tick <= ref_cnt == 4'(REF_CYC - 1);
			ref_cnt <= (ref_cnt == 4'(REF_CYC - 1)) ? 4'h0 : ref_cnt + 4'h1;
		end
	end

	// Fast rate is below one clock, so it runs every cycle
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fast_cnt <= 4'h0;
			fast_tick <= 1'b0;
		end else begin
			fast_tick <= fast_cnt == 4'(FAST_CYC - 1);
			fast_cnt <= (fast_cnt == 4'(FAST_CYC - 1)) ? 4'h0 : fast_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			adc_q <= '0;
		end else if (ref_tick) begin
			adc_q <= adc_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pos_q <= '0;
		end else if (rw_q[I_OUTPUT][`PLK_ABZ_ENABLE_BIT] ? ref_tick : fast_tick) begin
			pos_q <= pos_i;
		end
	end

	// Response follows the selection of the previous command
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resp_sel <= plk_pkg::PLK_RESP_POS;
			resp_addr <= 16'h0000;
		end else if (spi_cmd_valid_i) begin
			resp_sel <= spi_cmd_i.response_select;
			resp_addr <= spi_cmd_i.addr;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spi_resp_o <= 32'h0000_0000;
		end else begin
			unique case (resp_sel)
				plk_pkg::PLK_RESP_ADC: begin
					spi_resp_o <= {4'h0, adc_q.sine, adc_q.cosine, adc_q.index};
				end
				plk_pkg::PLK_RESP_REGPOS: begin
					spi_resp_o <= {rd_reg(resp_addr), pos_q.cycles, pos_q.angle};
				end
				plk_pkg::PLK_RESP_POS, plk_pkg::PLK_RESP_CAPT: begin
					// Status and capture formats are built elsewhere
					spi_resp_o <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule

// [verification/plk_host.sv]
// Host model: overdrives the quadrature pins and clocks link frames
`timescale 1ns/10ps
module plk_host (
	// Level of the A- wire
	input wire logic neg_i,
	// Host drive of A+ and A-
	output logic pos_o,
	output logic pos_oe_o,
	output logic neg_o,
	output logic neg_oe_o
);
	localparam int HALF_NS = 16;
	initial begin
		pos_o = 1'b0;
		pos_oe_o = 1'b0;
		neg_o = 1'b0;
		neg_oe_o = 1'b0;
	end
	// Both high, then both low and held low
	task automatic activate(input int high_ns);
		pos_oe_o = 1'b1;
		neg_oe_o = 1'b1;
		pos_o = 1'b1;
		neg_o = 1'b1;
		#(high_ns);
		pos_o = 1'b0;
		neg_o = 1'b0;
	endtask
	task automatic release_pins();
		pos_oe_o = 1'b0;
		neg_oe_o = 1'b0;
	endtask
	// Data set while clock low; sampled at the rise
	task automatic bit_io(input logic b, output logic s);
		neg_o = b;
		#(HALF_NS);
		pos_o = 1'b1;
		s = neg_i;
		#(HALF_NS);
		pos_o = 1'b0;
	endtask
	task automatic frame(input logic wr, input logic [15:0] addr, input logic [7:0] data,
			output logic [7:0] rd);
		logic [39:0] f;
		logic s;
		rd = 8'h00;
		f = {1'b1, wr, 6'h00, addr, wr ? data : 8'h00, 8'h00};
		// Leading zeros give the link side time to see its enable
		repeat (4) bit_io(1'b0, s);
		for (int i = 39; i >= (wr ? 8 : 0); i--) begin
			if (!wr && i == 15) begin
				neg_oe_o = 1'b0;
			end
			bit_io(f[i], s);
			if (i < 8) begin
				rd[i] = s;
			end
		end
		neg_o = 1'b0;
		neg_oe_o = 1'b1;
	endtask
endmodule

// [verification/plk_top_chk.sv]
// Port assertions for the register and overdrive link block
`timescale 1ns/10ps
`include "plk_map.svh"
module plk_top_chk #(
	parameter int ACT_MAX_CYC = 200
) (
	// Clock and resets
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic external_reset_n_i,
	// Pin enables
	input wire logic qa_pos_oe_o,
	input wire logic qa_neg_oe_o,
	input wire logic link_sdo_oe_o,
	// Serial port and sources
	input wire logic spi_cmd_valid_i,
	input wire plk_pkg::plk_spi_cmd_t spi_cmd_i,
	input wire logic [31:0] spi_resp_o,
	input wire plk_pkg::plk_adc_t adc_i,
	input wire plk_pkg::plk_pos_t pos_i,
	input wire logic restore_valid_i,
	// Status
	input wire logic [7:0] cfg_main_o,
	input wire logic [7:0] cfg_output_o,
	input wire logic link_active_o
);
	int blk_cnt;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Saturates so a long blocked span cannot wrap
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blk_cnt <= 0;
		end else if (!cfg_main_o[`PLK_LINK_OFF_BIT]) begin
			blk_cnt <= 0;
		end else if (blk_cnt < ACT_MAX_CYC + 100) begin
			blk_cnt <= blk_cnt + 1;
		end
	end
	sequence s_quiet_adc;
		(!spi_cmd_valid_i && $stable(adc_i)) [*8] ##1 (!spi_cmd_valid_i && $stable(adc_i)) [*4];
	endsequence
	sequence s_quiet_pos;
		(!spi_cmd_valid_i && $stable(pos_i)) [*8] ##1 (!spi_cmd_valid_i && $stable(pos_i)) [*4];
	endsequence
	property p_oe_link;
		link_active_o [*2] |-> !qa_pos_oe_o && !qa_neg_oe_o;
	endproperty
	a_oe_link: assert property (p_oe_link) else $error("pins driven while link active");
	property p_ext_drop;
		!external_reset_n_i [*6] |-> !link_active_o;
	endproperty
	a_ext_drop: assert property (p_ext_drop) else $error("link kept during reset pin");
	property p_block;
		$rose(link_active_o) |-> blk_cnt <= ACT_MAX_CYC + 8;
	endproperty
	a_block: assert property (p_block) else $error("link activated while disabled");
	property p_mode2;
		spi_cmd_valid_i && spi_cmd_i.response_select == plk_pkg::PLK_RESP_ADC ##1 s_quiet_adc
			|-> spi_resp_o == {4'h0, adc_i};
	endproperty
	a_mode2: assert property (p_mode2) else $error("sample word wrong");
	property p_mode3;
		spi_cmd_valid_i && spi_cmd_i.response_select == plk_pkg::PLK_RESP_REGPOS ##1 s_quiet_pos
			|-> spi_resp_o[23:0] == pos_i;
	endproperty
	a_mode3: assert property (p_mode3) else $error("position fields wrong");
	property p_sdo_len;
		$rose(link_sdo_oe_o) |-> link_sdo_oe_o [*6] ##[1:3] !link_sdo_oe_o;
	endproperty
	a_sdo_len: assert property (p_sdo_len) else $error("read drive span wrong");
	property p_cfg_write;
		spi_cmd_valid_i && spi_cmd_i.write_reg && spi_cmd_i.addr == `PLK_MAIN_CONFIGURATION
			|=> cfg_main_o == $past(spi_cmd_i.data);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("write not immediate");
	property p_static_hold;
		!$stable(cfg_output_o) |-> $past(spi_cmd_valid_i) || $past(restore_valid_i) || link_active_o;
	endproperty
	a_static_hold: assert property (p_static_hold) else $error("static changed alone");
	c_active: cover property (link_active_o [*2]);
	c_read: cover property ($rose(link_sdo_oe_o));
	c_write: cover property (spi_cmd_valid_i && spi_cmd_i.write_reg);
endmodule

// [verification/plk_top_tb.sv]
// Testbench for the register and overdrive link block
`timescale 1ns/10ps
`include "plk_map.svh"
`define PLK_CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module plk_top_tb;
	logic clk_sys_i, rst_n_i, external_reset_n_i, quad_a_i, spi_cmd_valid_i, restore_valid_i;
	plk_pkg::plk_spi_cmd_t spi_cmd_i;
	plk_pkg::plk_adc_t adc_i;
	plk_pkg::plk_pos_t pos_i;
	plk_pkg::plk_dyn_t dyn_i;
	plk_pkg::plk_reg_wr_t restore_i;
	logic qa_pos_o, qa_pos_oe_o, qa_neg_o, qa_neg_oe_o, link_sdo_o, link_sdo_oe_o;
	logic [31:0] spi_resp_o;
	logic [7:0] cfg_main_o, cfg_output_o, cmd_code_o, rd;
	logic cmd_valid_o, count_valid_o, link_active_o, h_pos, h_pos_oe, h_neg, h_neg_oe, flt;
	int fails = 0;
	int compares = 0;
	int cmd_pulses = 0;
	// Undriven wires wander rather than hold a value
	wire logic a_pos = h_pos_oe ? h_pos : (qa_pos_oe_o ? qa_pos_o : flt);
	wire logic a_neg = h_neg_oe ? h_neg :
		(link_sdo_oe_o ? link_sdo_o : (qa_neg_oe_o ? qa_neg_o : flt));
	plk_top #(.ACT_MIN_CYC(20), .ACT_MAX_CYC(200)) i_plk_top (
		.clk_sys_i, .rst_n_i, .link_clk_i(a_pos), .external_reset_n_i, .qa_pos_i(a_pos),
		.qa_pos_o, .qa_pos_oe_o, .qa_neg_i(a_neg), .qa_neg_o, .qa_neg_oe_o, .link_sdo_o,
		.link_sdo_oe_o, .quad_a_i, .spi_cmd_valid_i, .spi_cmd_i, .spi_resp_o, .adc_i, .pos_i,
		.dyn_i, .restore_valid_i, .restore_i, .cfg_main_o, .cfg_output_o, .cmd_valid_o,
		.cmd_code_o, .count_valid_o, .link_active_o
	);
	plk_host i_plk_host (.neg_i(a_neg), .pos_o(h_pos), .pos_oe_o(h_pos_oe), .neg_o(h_neg),
		.neg_oe_o(h_neg_oe));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) flt <= #1 ~flt;
	always @(posedge clk_sys_i) cmd_pulses <= cmd_pulses + int'(cmd_valid_o === 1'b1);
	always @(posedge clk_sys_i) quad_a_i <= #1 ~quad_a_i;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic spi(input logic [1:0] sel, input logic wr, input logic [15:0] a,
			input logic [7:0] d);
		tick(1);
		spi_cmd_valid_i = 1'b1;
		spi_cmd_i = {sel, wr, a, d};
		tick(1);
		spi_cmd_valid_i = 1'b0;
		tick(14);
	endtask
	task automatic test_regs();
		spi(2'd3, 1'b0, `PLK_MAIN_CONFIGURATION, 8'h00);
		`PLK_CHK(spi_resp_o[31:24], 8'h00)
		spi(2'd3, 1'b1, `PLK_OUTPUT_ENABLES_POLARITIES, 8'h40);
		`PLK_CHK(spi_resp_o, {8'h40, pos_i})
		`PLK_CHK(cfg_output_o, 8'h40)
		spi(2'd3, 1'b1, `PLK_LAMP_ACTUAL_DUTY, 8'h5a);
		`PLK_CHK(spi_resp_o[31:24], 8'h11)
		// Reserved bits written as zero; interpolation field clear sets count_valid_o
		spi(2'd3, 1'b1, `PLK_MAIN_CONFIGURATION, 8'h1f);
		`PLK_CHK(spi_resp_o[31:24], 8'h1f)
		spi(2'd3, 1'b1, `PLK_INTERPOLATION_LOW_BYTE, 8'h01);
		`PLK_CHK(count_valid_o, 1'b0)
		spi(2'd3, 1'b1, `PLK_INTERPOLATION_LOW_BYTE, 8'h00);
		`PLK_CHK(count_valid_o, 1'b1)
		spi(2'd2, 1'b0, 16'h0000, 8'h00);
		`PLK_CHK(spi_resp_o, {4'h0, adc_i})
		spi(2'd3, 1'b1, `PLK_OPERATION_COMMAND, 8'h03);
		`PLK_CHK(cmd_code_o, 8'h03)
		`PLK_CHK(cmd_pulses, 1)
		restore_valid_i = 1'b1;
		restore_i = {`PLK_COMMUTATION_HYSTERESIS, 8'h1f};
		tick(1);
		restore_valid_i = 1'b0;
		spi(2'd3, 1'b0, `PLK_COMMUTATION_HYSTERESIS, 8'h00);
		`PLK_CHK(spi_resp_o[31:24], 8'h1f)
		$display("test_regs done");
	endtask
	task automatic test_link();
		spi(2'd3, 1'b1, `PLK_MAIN_CONFIGURATION, 8'h20);
		i_plk_host.activate(2000);
		tick(10);
		`PLK_CHK(link_active_o, 1'b0)
		spi(2'd3, 1'b1, `PLK_MAIN_CONFIGURATION, 8'h00);
		i_plk_host.activate(2000);
		tick(10);
		`PLK_CHK(link_active_o, 1'b1)
		`PLK_CHK(qa_pos_oe_o, 1'b0)
		i_plk_host.frame(1'b1, `PLK_COMMUTATION_SETUP, 8'h15, rd);
		tick(8);
		spi(2'd3, 1'b0, `PLK_COMMUTATION_SETUP, 8'h00);
		`PLK_CHK(spi_resp_o[31:24], 8'h15)
		i_plk_host.frame(1'b0, `PLK_OUTPUT_ENABLES_POLARITIES, 8'h00, rd);
		`PLK_CHK(rd, 8'h40)
		i_plk_host.frame(1'b0, `PLK_COMMUTATION_SETUP, 8'h00, rd);
		`PLK_CHK(rd, 8'h15)
		tick(2);
		`PLK_CHK(link_active_o, 1'b1)
		$display("test_link done");
	endtask
	task automatic test_ext_reset();
		external_reset_n_i = 1'b0;
		tick(8);
		`PLK_CHK(link_active_o, 1'b0)
		i_plk_host.release_pins();
		external_reset_n_i = 1'b1;
		tick(4);
		`PLK_CHK(qa_neg_oe_o, 1'b1)
		`PLK_CHK(qa_pos_o ^ qa_neg_o, 1'b1)
		$display("test_ext_reset done");
	endtask
	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		rst_n_i = 1'b0;
		external_reset_n_i = 1'b1;
		quad_a_i = 1'b0;
		flt = 1'b0;
		spi_cmd_valid_i = 1'b0;
		spi_cmd_i = '0;
		restore_valid_i = 1'b0;
		restore_i = '0;
		adc_i = 28'h8a3c5e7;
		pos_i = 24'habcdef;
		dyn_i = 72'h998877665544332211;
		tick(4);
		rst_n_i = 1'b1;
		test_regs();
		test_link();
		test_ext_reset();
		test_done();
	end
	initial begin
		#200000;
		fails++;
		test_done();
	end
endmodule
bind plk_top plk_top_chk #(.ACT_MAX_CYC(ACT_MAX_CYC)) i_plk_top_chk (
	.clk_sys_i, .rst_n_i, .external_reset_n_i, .qa_pos_oe_o, .qa_neg_oe_o, .link_sdo_oe_o,
	.spi_cmd_valid_i, .spi_cmd_i, .spi_resp_o, .adc_i, .pos_i, .restore_valid_i, .cfg_main_o,
	.cfg_output_o, .link_active_o
);
